// [dv/sigmod_sources.sv]
// Purpose: far-side model of the on-chip signal sources and external pins
// Assumes: on-chip sources change with ref_clk; pins are asynchronous
// Notes: pins lag by 3 ns so that they never meet a clock edge
module sigmod_sources (
  input wire sigmod_pkg::source_bus_s src_cmd,
  input wire sigmod_pkg::pin_bus_s pin_cmd,
  output wire sigmod_pkg::source_bus_s sources,
  output wire sigmod_pkg::pin_bus_s pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // on-chip sources follow the commanded levels at once
  assign sources = src_cmd;
  // external pins arrive late, off the clock edge
  assign #3 pins = pin_cmd;
endmodule

// [dv/signal_modulator_tb.sv]
// Purpose: self-checking bench for the signal modulator
// Assumes: outputs follow same-clock inputs after 1 edge, pins after 3
// Notes: control rows first, then code sweeps, sync, reset
module signal_modulator_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic en; logic oe; logic sw; logic out; logic act;} row_s;
  // ---------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------
  localparam row_s ROWS [6] = '{5'h1F, 5'h15, 5'h0C, 5'h1F, 5'h18, 5'h04};
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic en = 1'h1;
  logic oe = 1'h1;
  logic sw = 1'h0;
  logic [3:0] msel = sigmod_pkg::MOD_SRC_SWBIT;
  sigmod_pkg::carrier_cfg_s chc = '0;
  sigmod_pkg::carrier_cfg_s clc = '0;
  sigmod_pkg::source_bus_s src = '0;
  sigmod_pkg::pin_bus_s pinc = '0;
  sigmod_pkg::source_bus_s srcs;
  sigmod_pkg::pin_bus_s pins;
  logic out;
  logic act;
  int fail_count = 0;
  int samples_checked = 0;
  always #10 ref_clk = ~ref_clk;
  sigmod_sources sigmod_sources_i (.src_cmd(src), .pin_cmd(pinc), .sources(srcs), .pins(pins));
  signal_modulator signal_modulator_i (.ref_clk(ref_clk), .rst(rst), .modulator_global_enable(en),
    .pin_output_enable(oe), .software_modulator_bit(sw), .modulator_source_select(msel),
    .carrier_high_cfg(chc), .carrier_low_cfg(clc), .sources(srcs), .pins(pins),
    .modulated_output_pin(out), .mixed_active(act));
  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask
  // raise only the source that code c names, all others low
  task automatic raise(input int c, input bit car);
    src = '0;
    pinc = '0;
    sw = 1'h0;
    if (c < 4)
      src.ccp[c] = 1'h1;
    else if (car)
      case (c)
        4: src.refclk = 1'h1;
        5: pinc.carrier_pin_one = 1'h1;
        6: pinc.carrier_pin_two = 1'h1;
        default: ;
      endcase
    else
      case (c)
        4, 5: src.sdo[c-4] = 1'h1;
        6, 7: src.cmp[c-6] = 1'h1;
        8: src.tx = 1'h1;
        9: pinc.pin = 1'h1;
        default: sw = 1'h1;
      endcase
  endtask
  // carrier low on capture unit one, carrier high on unit two, modulator on the software bit
  task automatic sync_case(input logic hs, input logic ls);
    msel = sigmod_pkg::MOD_SRC_SWBIT;
    chc = '{sigmod_pkg::CAR_SRC_CAPCMP2, hs};
    clc = '{sigmod_pkg::CAR_SRC_CAPCMP1, ls};
    src = '0;
    src.ccp[0] = 1'h1;
    sw = 1'h0;
    step(2);
    sw = 1'h1;
    step(1);
    check("leave_low", ls, out);
    src.ccp[0] = 1'h0;
    step(1);
    check("low_fell", 1'h0, out);
    src.ccp[1] = 1'h1;
    step(1);
    check("high_now", 1'h1, out);
    sw = 1'h0;
    step(1);
    check("leave_high", hs, out);
    src.ccp[1] = 1'h0;
    step(1);
    check("high_fell", 1'h0, out);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ---------------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------------
  initial
  begin
    #200000;
    fail_count++;
    finish_test();
  end
  initial
  begin
    chc = '{sigmod_pkg::CAR_SRC_REFCLK, 1'h0};
    clc = '{sigmod_pkg::CAR_SRC_CAPCMP1, 1'h0};
    src.refclk = 1'h1;
    step(5);
    rst = 1'h0;
    foreach (ROWS[i])
    begin
      {en, oe, sw} = {ROWS[i].en, ROWS[i].oe, ROWS[i].sw};
      step(1);
      check("row_out", ROWS[i].out, out);
      check("row_act", ROWS[i].act, act);
    end
    $display("test control rows done");
    {en, oe} = 2'h3;
    clc = '{sigmod_pkg::CAR_SRC_VSS, 1'h0};
    for (int c = 0; c < 11; c++)
    begin
      raise(c, 1'b0);
      src.refclk = 1'h1;
      msel = c[3:0];
      step(4);
      check("mod_code", 1'h1, out);
    end
    msel = 4'hB;
    step(2);
    check("mod_refused", 1'h0, out);
    $display("test modulator codes done");
    msel = sigmod_pkg::MOD_SRC_SWBIT;
    for (int c = 0; c < 8; c++)
    begin
      raise(c, 1'b1);
      sw = 1'h1;
      chc = '{c[3:0], 1'h0};
      clc = '{sigmod_pkg::CAR_SRC_VSS, 1'h0};
      step(4);
      check("high_code", c != 7, out);
      sw = 1'h0;
      chc = '{sigmod_pkg::CAR_SRC_VSS, 1'h0};
      clc = '{c[3:0], 1'h0};
      step(2);
      check("low_code", c != 7, out);
    end
    $display("test carrier codes done");
    for (int i = 0; i < 4; i++) sync_case(i[0], i[1]);
    $display("test sync done");
    src.ccp[0] = 1'h1;
    rst = 1'h1;
    step(1);
    check("reset_out", 1'h0, out);
    check("reset_act", 1'h0, act);
    rst = 1'h0;
    step(1);
    check("after_reset", 1'h1, act);
    check("after_reset_out", 1'h1, out);
    $display("test reset done");
    finish_test();
  end
endmodule

// [rtl/sigmod_pkg.sv]
// Purpose: shared constants and types for the signal modulator
// Assumes: one 50 MHz clock, no register bus
// Notes: select encodings are free choices of this block
package sigmod_pkg;

  // ----------------------------------------------------------------------
  // select field layout
  // ----------------------------------------------------------------------
  localparam int SEL_W = 4;
  localparam logic [3:0] SEL_RESET = 4'h0;

  // modulator source codes
  localparam logic [3:0] MOD_SRC_CAPCMP1 = 4'h0;
  localparam logic [3:0] MOD_SRC_CAPCMP2 = 4'h1;
  localparam logic [3:0] MOD_SRC_CAPCMP3 = 4'h2;
  localparam logic [3:0] MOD_SRC_CAPCMP4 = 4'h3;
  localparam logic [3:0] MOD_SRC_SDO1 = 4'h4;
  localparam logic [3:0] MOD_SRC_SDO2 = 4'h5;
  localparam logic [3:0] MOD_SRC_CMP1 = 4'h6;
  localparam logic [3:0] MOD_SRC_CMP2 = 4'h7;
  localparam logic [3:0] MOD_SRC_TX = 4'h8;
  localparam logic [3:0] MOD_SRC_PIN = 4'h9;
  localparam logic [3:0] MOD_SRC_SWBIT = 4'hA;

  // carrier source codes, shared by carrier high and carrier low
  localparam logic [3:0] CAR_SRC_CAPCMP1 = 4'h0;
  localparam logic [3:0] CAR_SRC_CAPCMP2 = 4'h1;
  localparam logic [3:0] CAR_SRC_CAPCMP3 = 4'h2;
  localparam logic [3:0] CAR_SRC_CAPCMP4 = 4'h3;
  localparam logic [3:0] CAR_SRC_REFCLK = 4'h4;
  localparam logic [3:0] CAR_SRC_PIN1 = 4'h5;
  localparam logic [3:0] CAR_SRC_PIN2 = 4'h6;
  localparam logic [3:0] CAR_SRC_VSS = 4'h7;

  // ----------------------------------------------------------------------
  // carrier configuration and source buses
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] select;
    logic sync;
  } carrier_cfg_s;

  typedef struct packed {
    logic [3:0] ccp;
    logic [1:0] sdo;
    logic [1:0] cmp;
    logic tx;
    logic refclk;
  } source_bus_s;

  typedef struct packed {
    logic pin;
    logic carrier_pin_one;
    logic carrier_pin_two;
  } pin_bus_s;

endpackage

// [rtl/signal_modulator.sv]
// Purpose: data signal modulator mixing a modulator with carrier high and low
// Assumes: on-chip sources share ref_clk; pins are synchronised here
// Notes: output registered; selections held in ports owned by the caller
module signal_modulator (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic modulator_global_enable,
  input wire logic pin_output_enable,
  input wire logic software_modulator_bit,
  input wire logic [3:0] modulator_source_select,
  input wire sigmod_pkg::carrier_cfg_s carrier_high_cfg,
  input wire sigmod_pkg::carrier_cfg_s carrier_low_cfg,
  input wire sigmod_pkg::source_bus_s sources,
  input wire sigmod_pkg::pin_bus_s pins,
  output logic modulated_output_pin,
  output logic mixed_active
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  sigmod_pkg::pin_bus_s pin_meta_q;
  sigmod_pkg::pin_bus_s pin_sync_q;

  // two flops before any logic reads the external pins
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end
    else
    begin
      pin_meta_q <= pins;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------------
  function automatic logic pick_carrier(input logic [3:0] sel, input sigmod_pkg::source_bus_s s,
                                        input sigmod_pkg::pin_bus_s p);
    logic r;
    r = 1'b0;
    unique case (sel)
      sigmod_pkg::CAR_SRC_CAPCMP1: r = s.ccp[0];
      sigmod_pkg::CAR_SRC_CAPCMP2: r = s.ccp[1];
      sigmod_pkg::CAR_SRC_CAPCMP3: r = s.ccp[2];
      sigmod_pkg::CAR_SRC_CAPCMP4: r = s.ccp[3];
      sigmod_pkg::CAR_SRC_REFCLK: r = s.refclk;
      sigmod_pkg::CAR_SRC_PIN1: r = p.carrier_pin_one;
      sigmod_pkg::CAR_SRC_PIN2: r = p.carrier_pin_two;
      default: r = 1'b0; // ground and unused codes
    endcase
    return r;
  endfunction

  logic mod_sel_raw;
  logic mod_in;
  logic car_high_in;
  logic car_low_in;

  // modulator mux; unused codes read as low
  always_comb
  begin
    mod_sel_raw = 1'b0;
    unique case (modulator_source_select)
      sigmod_pkg::MOD_SRC_CAPCMP1: mod_sel_raw = sources.ccp[0];
      sigmod_pkg::MOD_SRC_CAPCMP2: mod_sel_raw = sources.ccp[1];
      sigmod_pkg::MOD_SRC_CAPCMP3: mod_sel_raw = sources.ccp[2];
      sigmod_pkg::MOD_SRC_CAPCMP4: mod_sel_raw = sources.ccp[3];
      sigmod_pkg::MOD_SRC_SDO1: mod_sel_raw = sources.sdo[0];
      sigmod_pkg::MOD_SRC_SDO2: mod_sel_raw = sources.sdo[1];
      sigmod_pkg::MOD_SRC_CMP1: mod_sel_raw = sources.cmp[0];
      sigmod_pkg::MOD_SRC_CMP2: mod_sel_raw = sources.cmp[1];
      sigmod_pkg::MOD_SRC_TX: mod_sel_raw = sources.tx;
      sigmod_pkg::MOD_SRC_PIN: mod_sel_raw = pin_sync_q.pin;
      sigmod_pkg::MOD_SRC_SWBIT: mod_sel_raw = software_modulator_bit;
      default: mod_sel_raw = 1'b0;
    endcase
  end

  // disabled: software bit drives the modulator, carriers tied to ground;
  // the select inputs are only gated, never altered, so re-enable restores them
  assign mod_in = modulator_global_enable ? mod_sel_raw : software_modulator_bit;
  assign car_high_in = modulator_global_enable &
                       pick_carrier(carrier_high_cfg.select, sources, pin_sync_q);
  assign car_low_in = modulator_global_enable &
                      pick_carrier(carrier_low_cfg.select, sources, pin_sync_q);

  // ----------------------------------------------------------------------
  // mixing with carrier synchronisation
  // ----------------------------------------------------------------------
  logic mod_q;
  logic use_high_q;
  logic use_high_d;
  logic mod_edge;
  logic old_car;
  logic old_sync;
  logic mix;

  // a modulator change requests the other carrier; with sync on the
  // carrier being left, the switch waits until that carrier is low
  assign mod_edge = (mod_in != mod_q);
  assign old_car = use_high_q ? car_high_in : car_low_in;
  assign old_sync = use_high_q ? carrier_high_cfg.sync : carrier_low_cfg.sync;
  assign use_high_d = (use_high_q == mod_in) ? use_high_q :
                      (!old_sync ? mod_in :
                       (old_car ? use_high_q : mod_in));
  assign mix = use_high_d ? car_high_in : car_low_in;

  // modulator history, carrier choice and registered output
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mod_q <= 1'b0;
      use_high_q <= 1'b0;
      modulated_output_pin <= 1'b0;
      mixed_active <= 1'b0;
    end
    else
    begin
      mod_q <= mod_in;
      use_high_q <= use_high_d;
      mixed_active <= mix; // mixing continues even with the pin off
      modulated_output_pin <= pin_output_enable & mix;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence pin_off_s;
    !pin_output_enable;
  endsequence

  chk_pin_low_off: assert property (@(posedge ref_clk) disable iff (rst)
    pin_off_s |=> !modulated_output_pin)
    else $error("output pin high while output enable clear");

  chk_mix_keeps_running: assert property (@(posedge ref_clk) disable iff (rst)
    (!pin_output_enable && modulator_global_enable && mod_in && use_high_q)
      |=> mixed_active == $past(car_high_in))
    else $error("mixing stopped");

  chk_pin_follows_mix: assert property (@(posedge ref_clk) disable iff (rst)
    (pin_output_enable && modulator_global_enable && !mod_in && !use_high_q)
      |=> modulated_output_pin == $past(car_low_in))
    else $error("pin differs from mix while enabled");

  chk_disabled_ground: assert property (@(posedge ref_clk) disable iff (rst)
    !modulator_global_enable |=> !mixed_active)
    else $error("carrier active while disabled");

  chk_disabled_swbit: assert property (@(posedge ref_clk) disable iff (rst)
    !modulator_global_enable |-> mod_in == software_modulator_bit)
    else $error("modulator not from software bit while disabled");

  chk_nosync_switch: assert property (@(posedge ref_clk) disable iff (rst)
    (mod_edge && !old_sync) |=> use_high_q == $past(mod_in))
    else $error("unsynchronised switch delayed");

  chk_sync_hold_high: assert property (@(posedge ref_clk) disable iff (rst)
    (use_high_q != mod_in && old_sync && old_car) |=> use_high_q == $past(use_high_q))
    else $error("synchronised carrier cut while high");

  chk_sync_release: assert property (@(posedge ref_clk) disable iff (rst)
    (use_high_q != mod_in && old_sync && !old_car) |=> use_high_q == $past(mod_in))
    else $error("synchronised switch missed low carrier");

  // modulator decode, one check per code; refused codes read low
  chk_mod_capcmp_one: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && modulator_source_select == sigmod_pkg::MOD_SRC_CAPCMP1)
      |-> mod_in == sources.ccp[0])
    else $error("modulator select wrong for capture unit one");

  chk_mod_capcmp_two: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && modulator_source_select == sigmod_pkg::MOD_SRC_CAPCMP2)
      |-> mod_in == sources.ccp[1])
    else $error("modulator select wrong for capture unit two");

  chk_mod_capcmp_three: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && modulator_source_select == sigmod_pkg::MOD_SRC_CAPCMP3)
      |-> mod_in == sources.ccp[2])
    else $error("modulator select wrong for capture unit three");

  chk_mod_capcmp_four: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && modulator_source_select == sigmod_pkg::MOD_SRC_CAPCMP4)
      |-> mod_in == sources.ccp[3])
    else $error("modulator select wrong for capture unit four");

  chk_mod_sdo_one: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && modulator_source_select == sigmod_pkg::MOD_SRC_SDO1)
      |-> mod_in == sources.sdo[0])
    else $error("modulator select wrong for serial data one");

  chk_mod_sdo_two: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && modulator_source_select == sigmod_pkg::MOD_SRC_SDO2)
      |-> mod_in == sources.sdo[1])
    else $error("modulator select wrong for serial data two");

  chk_mod_cmp_one: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && modulator_source_select == sigmod_pkg::MOD_SRC_CMP1)
      |-> mod_in == sources.cmp[0])
    else $error("modulator select wrong for comparator one");

  chk_mod_cmp_two: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && modulator_source_select == sigmod_pkg::MOD_SRC_CMP2)
      |-> mod_in == sources.cmp[1])
    else $error("modulator select wrong for comparator two");

  chk_mod_tx_line: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && modulator_source_select == sigmod_pkg::MOD_SRC_TX)
      |-> mod_in == sources.tx)
    else $error("modulator select wrong for transmit line");

  chk_mod_ext_pin: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && modulator_source_select == sigmod_pkg::MOD_SRC_PIN)
      |-> mod_in == pin_sync_q.pin)
    else $error("modulator select wrong for external pin");

  chk_mod_sw_bit: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && modulator_source_select == sigmod_pkg::MOD_SRC_SWBIT)
      |-> mod_in == software_modulator_bit)
    else $error("modulator select wrong for software bit");

  chk_mod_refused: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && modulator_source_select > sigmod_pkg::MOD_SRC_SWBIT)
      |-> !mod_in)
    else $error("modulator high on a refused select code");

  // carrier high decode, one check per code; ground and refused codes read low
  chk_high_capcmp_one: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_high_cfg.select == sigmod_pkg::CAR_SRC_CAPCMP1)
      |-> car_high_in == sources.ccp[0])
    else $error("carrier high select wrong for capture unit one");

  chk_high_capcmp_two: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_high_cfg.select == sigmod_pkg::CAR_SRC_CAPCMP2)
      |-> car_high_in == sources.ccp[1])
    else $error("carrier high select wrong for capture unit two");

  chk_high_capcmp_three: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_high_cfg.select == sigmod_pkg::CAR_SRC_CAPCMP3)
      |-> car_high_in == sources.ccp[2])
    else $error("carrier high select wrong for capture unit three");

  chk_high_capcmp_four: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_high_cfg.select == sigmod_pkg::CAR_SRC_CAPCMP4)
      |-> car_high_in == sources.ccp[3])
    else $error("carrier high select wrong for capture unit four");

  chk_high_ref_clock: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_high_cfg.select == sigmod_pkg::CAR_SRC_REFCLK)
      |-> car_high_in == sources.refclk)
    else $error("carrier high select wrong for reference clock");

  chk_high_pin_one: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_high_cfg.select == sigmod_pkg::CAR_SRC_PIN1)
      |-> car_high_in == pin_sync_q.carrier_pin_one)
    else $error("carrier high select wrong for carrier pin one");

  chk_high_pin_two: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_high_cfg.select == sigmod_pkg::CAR_SRC_PIN2)
      |-> car_high_in == pin_sync_q.carrier_pin_two)
    else $error("carrier high select wrong for carrier pin two");

  chk_high_ground: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_high_cfg.select >= sigmod_pkg::CAR_SRC_VSS)
      |-> !car_high_in)
    else $error("carrier high not grounded");

  // carrier low decode, same eight choices as carrier high
  chk_low_capcmp_one: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_low_cfg.select == sigmod_pkg::CAR_SRC_CAPCMP1)
      |-> car_low_in == sources.ccp[0])
    else $error("carrier low select wrong for capture unit one");

  chk_low_capcmp_two: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_low_cfg.select == sigmod_pkg::CAR_SRC_CAPCMP2)
      |-> car_low_in == sources.ccp[1])
    else $error("carrier low select wrong for capture unit two");

  chk_low_capcmp_three: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_low_cfg.select == sigmod_pkg::CAR_SRC_CAPCMP3)
      |-> car_low_in == sources.ccp[2])
    else $error("carrier low select wrong for capture unit three");

  chk_low_capcmp_four: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_low_cfg.select == sigmod_pkg::CAR_SRC_CAPCMP4)
      |-> car_low_in == sources.ccp[3])
    else $error("carrier low select wrong for capture unit four");

  chk_low_ref_clock: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_low_cfg.select == sigmod_pkg::CAR_SRC_REFCLK)
      |-> car_low_in == sources.refclk)
    else $error("carrier low select wrong for reference clock");

  chk_low_pin_one: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_low_cfg.select == sigmod_pkg::CAR_SRC_PIN1)
      |-> car_low_in == pin_sync_q.carrier_pin_one)
    else $error("carrier low select wrong for carrier pin one");

  chk_low_pin_two: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_low_cfg.select == sigmod_pkg::CAR_SRC_PIN2)
      |-> car_low_in == pin_sync_q.carrier_pin_two)
    else $error("carrier low select wrong for carrier pin two");

  chk_low_ground: assert property (@(posedge ref_clk) disable iff (rst)
    (modulator_global_enable && carrier_low_cfg.select >= sigmod_pkg::CAR_SRC_VSS)
      |-> !car_low_in)
    else $error("carrier low not grounded");

endmodule
